// ---- src/ioc_consts.svh ----
// constants for the io cell register logic: offsets, fields, resets, timing
// assumes inclusion wherever port widths or config fields are needed
`ifndef IOC_CONSTS_SVH
`define IOC_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define IOC_ADDR_W 8
`define IOC_DATA_W 32
`define IOC_OFS_CFG 8'h00
`define IOC_OFS_STAT 8'h04

// ==========================================================
// config field positions
`define IOC_CFG_IN_RATE_LSB 0
`define IOC_CFG_OUT_RATE_LSB 2
`define IOC_CFG_OUT_LATCH 4
`define IOC_CFG_BYPASS 5
`define IOC_CFG_FIX_LAG_EN 6
`define IOC_CFG_OE_REG 7
`define IOC_CFG_INIT_DATA 8
`define IOC_CFG_INIT_OE 9
`define IOC_CFG_W 10
`define IOC_CFG_RST 10'h080

// ==========================================================
// timing
`define IOC_FIX_LAG_NS 5
`define IOC_CLK_PERIOD_NS 5
`define IOC_FIX_LAG_CYC (`IOC_FIX_LAG_NS / `IOC_CLK_PERIOD_NS)
`define IOC_LAG_SET_W 5

`endif

// ---- src/ioc_pkg.sv ----
// types shared by the io cell register logic
// assumes ioc_consts.svh on the include path
`include "ioc_consts.svh"

package ioc_pkg;

    // ==========================================================
    // rate modes of input and output register blocks
    typedef enum logic [1:0] {
        RATE_SDR = 2'b00,
        RATE_GDDR = 2'b01,
        RATE_MDDR = 2'b10
    } ioc_rate_t;

    typedef enum logic [1:0] {
        EDGE_LEFT = 2'b00,
        EDGE_TOP = 2'b01,
        EDGE_BOTTOM = 2'b10,
        EDGE_RIGHT = 2'b11
    } ioc_edge_t;

    // ==========================================================
    // software configuration word, msb first
    typedef struct packed {
        logic initOe;
        logic initData;
        logic oeReg;
        logic fixLagEn;
        logic bypass;
        logic outLatch;
        logic [1:0] outRate;
        logic [1:0] inRate;
    } ioc_cfg_t;

    // pair of captured input streams
    typedef struct packed {
        logic rise;
        logic fall;
    } ioc_cap_t;

endpackage : ioc_pkg

// ---- src/ioc_cell_logic.sv ----
// io cell register logic: input, output and tri-state register stages
// assumes pad buffer outside, core fabric on core_clk, strobe logic outside
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"

module ioc_cell_logic #(
    parameter ioc_pkg::ioc_edge_t EDGE = ioc_pkg::EDGE_RIGHT,
    parameter bit MID_PLUS = 1'b1,
    parameter int FIX_LAG = `IOC_FIX_LAG_CYC
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic local_sr,
    input wire logic pad_in,
    output logic pad_data_out,
    output logic pad_oe_ctrl,
    output logic bypass_comb_in,
    output logic bypass_clock_out,
    output logic rise_capture_out,
    output logic fall_capture_out,
    input wire logic core_out_bit_a,
    input wire logic core_out_bit_b,
    input wire logic core_oe_ctrl,
    input wire logic strobe_read_shift_clk,
    input wire logic strobe_write_shift_clk,
    input wire logic capture_phase_select,
    input wire logic [`IOC_LAG_SET_W-1:0] input_lag_setting,
    input wire logic [`IOC_ADDR_W-1:0] reg_addr,
    input wire logic [`IOC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`IOC_DATA_W-1:0] reg_rdata
);

    localparam bit IS_RIGHT = (EDGE == ioc_pkg::EDGE_RIGHT);
    localparam bit IS_BOTTOM = (EDGE == ioc_pkg::EDGE_BOTTOM);
    localparam bit IN_GEAR = IS_BOTTOM && MID_PLUS;
    localparam bit OUT_GEAR = (EDGE == ioc_pkg::EDGE_TOP) && MID_PLUS;
    localparam int LAG_DEPTH = FIX_LAG + (1 << `IOC_LAG_SET_W);

    // ==========================================================
    // reset release
    logic [1:0] rstPipe_q;
    logic rstSync_n;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe_q <= 2'h0;
        end else begin
            rstPipe_q <= {rstPipe_q[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe_q[1];

    // ==========================================================
    // strobe-side level synchronisers
    logic [1:0] phaseSync_q;
    logic [1:0] readStbSync_q;
    logic phaseSel;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            phaseSync_q <= 2'h0;
            readStbSync_q <= 2'h0;
        end else if (ce) begin
            phaseSync_q <= {phaseSync_q[0], capture_phase_select};
            readStbSync_q <= {readStbSync_q[0], strobe_read_shift_clk};
        end
    end
    // other edges ignore the polarity input; phaseSel stays low
    assign phaseSel = IS_RIGHT & phaseSync_q[1];

    // ==========================================================
    // configuration register
    ioc_pkg::ioc_cfg_t cfg_q;
    ioc_pkg::ioc_rate_t inRate;
    ioc_pkg::ioc_rate_t outRate;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cfg_q <= `IOC_CFG_RST;
        end else if (ce && reg_wr && reg_addr == `IOC_OFS_CFG) begin
            cfg_q <= reg_wdata[`IOC_CFG_W-1:0];
        end
    end

    // memory mode falls back to generic off the right edge; code 3 is sdr
    function automatic ioc_pkg::ioc_rate_t effRate(input logic [1:0] code);
        ioc_pkg::ioc_rate_t r;
        r = ioc_pkg::RATE_SDR;
        if (code == 2'h1) begin
            r = ioc_pkg::RATE_GDDR;
        end else if (code == 2'h2) begin
            r = IS_RIGHT ? ioc_pkg::RATE_MDDR : ioc_pkg::RATE_GDDR;
        end
        return r;
    endfunction

    assign inRate = effRate(cfg_q.inRate);
    assign outRate = effRate(cfg_q.outRate);

    // ==========================================================
    // input delay line
    logic [LAG_DEPTH-1:0] lagLine_q;
    logic lagged;
    logic capSrc;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            lagLine_q <= '0;
        end else if (ce) begin
            lagLine_q <= {lagLine_q[LAG_DEPTH-2:0], pad_in};
        end
    end

    // tap count: fixed part plus the bottom-edge dynamic part
    always_comb begin
        int tap;
        tap = 0;
        if (cfg_q.fixLagEn) begin
            tap = FIX_LAG;
        end
        if (IS_BOTTOM) begin
            tap = tap + int'(input_lag_setting);
        end
        lagged = (tap == 0) ? pad_in : lagLine_q[tap-1];
    end

    // bypass skips the delay line but not the capture stage
    assign capSrc = cfg_q.bypass ? pad_in : lagged;
    assign bypass_comb_in = cfg_q.bypass & pad_in;
    assign bypass_clock_out = cfg_q.bypass & pad_in;

    // ==========================================================
    // input register block
    logic posCap_q;
    logic negCap_q;
    ioc_pkg::ioc_cap_t cap;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            posCap_q <= 1'b0;
        end else if (local_sr) begin
            posCap_q <= cfg_q.initData;
        end else if (ce) begin
            posCap_q <= capSrc;
        end
    end

    always_ff @(negedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            negCap_q <= 1'b0;
        end else if (local_sr) begin
            negCap_q <= cfg_q.initData;
        end else if (ce && inRate != ioc_pkg::RATE_SDR) begin
            negCap_q <= capSrc;
        end
    end

    always_comb begin
        unique case (inRate)
            ioc_pkg::ioc_rate_t'(ioc_pkg::RATE_SDR): begin
                cap.rise = 1'b0;
                cap.fall = posCap_q;
            end
            ioc_pkg::ioc_rate_t'(ioc_pkg::RATE_MDDR): begin
                // strobe polarity swaps which phase counts as positive
                cap.rise = phaseSel ? negCap_q : posCap_q;
                cap.fall = phaseSel ? posCap_q : negCap_q;
            end
            default: begin
                cap.rise = posCap_q;
                cap.fall = negCap_q;
            end
        endcase
    end
    assign rise_capture_out = cap.rise;
    assign fall_capture_out = cap.fall;

    // ==========================================================
    // output register block
    logic bitA_q;
    logic bitB_q;
    logic bitBFall_q;
    logic latchHold_q;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bitA_q <= 1'b0;
            bitB_q <= 1'b0;
        end else if (local_sr) begin
            bitA_q <= cfg_q.initData;
            bitB_q <= cfg_q.initData;
        end else if (ce) begin
            bitA_q <= core_out_bit_a;
            bitB_q <= core_out_bit_b;
        end
    end

    always_ff @(negedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            bitBFall_q <= 1'b0;
            latchHold_q <= 1'b0;
        end else if (local_sr) begin
            bitBFall_q <= cfg_q.initData;
            latchHold_q <= cfg_q.initData;
        end else if (ce) begin
            bitBFall_q <= bitB_q;
            latchHold_q <= core_out_bit_a;
        end
    end

    // clock-class selects drive the pad mux; this is the launch point itself
    always_comb begin
        unique case (outRate)
            ioc_pkg::ioc_rate_t'(ioc_pkg::RATE_SDR): begin
                if (cfg_q.outLatch) begin
                    // transparent while the clock is high, holds while low
                    pad_data_out = (core_clk && ce && !local_sr) ? core_out_bit_a
                                                                : latchHold_q;
                end else begin
                    pad_data_out = bitA_q;
                end
            end
            ioc_pkg::ioc_rate_t'(ioc_pkg::RATE_MDDR): begin
                pad_data_out = strobe_write_shift_clk ? bitA_q : bitBFall_q;
            end
            default: begin
                pad_data_out = core_clk ? bitA_q : bitBFall_q;
            end
        endcase
    end

    // ==========================================================
    // tri-state register block
    logic oe_q;

    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            oe_q <= 1'b0;
        end else if (local_sr) begin
            oe_q <= cfg_q.initOe;
        end else if (ce) begin
            oe_q <= core_oe_ctrl;
        end
    end

    // shared clock with the other two stages
    assign pad_oe_ctrl = cfg_q.oeReg ? oe_q : core_oe_ctrl;

    // ==========================================================
    // register read port
    logic [`IOC_DATA_W-1:0] stat;

    always_comb begin
        stat = '0;
        stat[0] = cap.rise;
        stat[1] = cap.fall;
        stat[2] = bitA_q;
        stat[3] = bitBFall_q;
        stat[4] = oe_q;
        stat[5] = phaseSel;
        stat[6] = IS_RIGHT & readStbSync_q[1];
        stat[7] = IN_GEAR;
        stat[8] = OUT_GEAR;
        stat[9] = IS_RIGHT;
    end

    // read data live after the strobe until the next ce cycle without a read strobe
    always_ff @(posedge core_clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            reg_rdata <= '0;
        end else if (ce) begin
            if (reg_rd && reg_addr == `IOC_OFS_CFG) begin
                reg_rdata <= {{(`IOC_DATA_W-`IOC_CFG_W){1'b0}}, cfg_q};
            end else if (reg_rd && reg_addr == `IOC_OFS_STAT) begin
                reg_rdata <= stat;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

endmodule // ioc_cell_logic
`default_nettype wire

// ---- dv/ioc_pad_model.sv ----
// pad buffer model on the far side of the io cell
// assumes the bench drives extVal when the cell is not driving
`timescale 1ns/1ps
`default_nettype none
module ioc_pad_model (
    input wire logic oe,
    input wire logic dOut,
    input wire logic extVal,
    output logic padIn
);
    // ======
    // pad wire: a driven pad reads back its own level
    assign padIn = oe ? dOut : extVal;
endmodule // ioc_pad_model
`default_nettype wire

// ---- dv/ioc_cell_chk.sv ----
// port assertions for the io cell register logic
// assumes one clock; config shadowed from register writes
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"
module ioc_cell_chk (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic local_sr,
    input wire logic pad_in,
    input wire logic pad_data_out,
    input wire logic pad_oe_ctrl,
    input wire logic bypass_comb_in,
    input wire logic bypass_clock_out,
    input wire logic rise_capture_out,
    input wire logic fall_capture_out,
    input wire logic core_out_bit_a,
    input wire logic core_oe_ctrl,
    input wire logic [`IOC_ADDR_W-1:0] reg_addr,
    input wire logic [`IOC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`IOC_DATA_W-1:0] reg_rdata
);
    // ======
    // helpers: internal reset lags rst_n by two edges
    ioc_pkg::ioc_cfg_t cfgQ;
    logic [1:0] upQ;
    logic live;
    logic run;
    assign live = upQ[1];
    assign run = live && ce && !local_sr && !reg_wr;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            upQ <= 2'h0;
        end else begin
            upQ <= {upQ[0], 1'b1};
        end
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgQ <= ioc_pkg::ioc_cfg_t'(`IOC_CFG_RST);
        end else if (reg_wr && ce && reg_addr == `IOC_OFS_CFG) begin
            cfgQ <= ioc_pkg::ioc_cfg_t'(reg_wdata[`IOC_CFG_W-1:0]);
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_sr_req;
        live && local_sr && cfgQ.oeReg && !reg_wr;
    endsequence
    sequence s_rd_once;
        reg_rd && ce ##1 !reg_rd && ce;
    endsequence
    // ======
    // assertions
    chk_bypass_pair: assert property (bypass_clock_out == bypass_comb_in)
        else $error("bypass clock and data differ");
    chk_bypass_gate: assert property (live && !cfgQ.bypass |-> !bypass_comb_in)
        else $error("bypass active while off");
    chk_sdr_capture: assert property (run && cfgQ.inRate == ioc_pkg::RATE_SDR &&
        !cfgQ.fixLagEn |=> fall_capture_out == $past(pad_in)) else $error("sdr capture");
    chk_ddr_rise: assert property (run && cfgQ.inRate == ioc_pkg::RATE_GDDR &&
        !cfgQ.fixLagEn |=> rise_capture_out == $past(pad_in)) else $error("rise capture");
    chk_sdr_launch: assert property (run && cfgQ.outRate == ioc_pkg::RATE_SDR &&
        !cfgQ.outLatch |=> pad_data_out == $past(core_out_bit_a)) else $error("sdr launch");
    chk_oe_reg: assert property (run && cfgQ.oeReg |=> pad_oe_ctrl == $past(core_oe_ctrl))
        else $error("registered oe");
    chk_oe_pass: assert property (live && !cfgQ.oeReg |-> pad_oe_ctrl == core_oe_ctrl)
        else $error("passed oe");
    chk_ce_hold: assert property (live && !ce && !local_sr && cfgQ.oeReg |=>
        $stable(pad_oe_ctrl) && $stable(fall_capture_out)) else $error("hold broken");
    chk_sr_init: assert property (s_sr_req |=> pad_oe_ctrl == $past(cfgQ.initOe))
        else $error("set reset oe");
    // read data must drop back to zero once its single cycle is over
    chk_rd_release: assert property (s_rd_once |=> reg_rdata == '0)
        else $error("read data stands too long");
endmodule // ioc_cell_chk
bind ioc_cell_logic ioc_cell_chk u_ioc_cell_chk (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .local_sr(local_sr), .pad_in(pad_in),
    .pad_data_out(pad_data_out), .pad_oe_ctrl(pad_oe_ctrl), .bypass_comb_in(bypass_comb_in),
    .bypass_clock_out(bypass_clock_out), .rise_capture_out(rise_capture_out),
    .fall_capture_out(fall_capture_out), .core_out_bit_a(core_out_bit_a),
    .core_oe_ctrl(core_oe_ctrl), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);
`default_nettype wire

// ---- dv/test_ioc_cell_logic.sv ----
// self-checking bench for the io cell register logic
// assumes pad model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ioc_consts.svh"
module test_ioc_cell_logic;
    logic coreClk, rstN, ce, localSr, padIn, padExt, padOut, padOe;
    logic byComb, byClk, riseCap, fallCap, bitA, bitB, oeCore, strobeW, capPol;
    logic [`IOC_ADDR_W-1:0] regAddr;
    logic [`IOC_DATA_W-1:0] regWdata, regRdata, rv;
    logic regWr, regRd;
    int badCount, totalChecks;
    ioc_cell_logic u_ioc_cell_logic (
        .core_clk(coreClk), .rst_n(rstN), .ce(ce), .local_sr(localSr), .pad_in(padIn),
        .pad_data_out(padOut), .pad_oe_ctrl(padOe), .bypass_comb_in(byComb),
        .bypass_clock_out(byClk), .rise_capture_out(riseCap), .fall_capture_out(fallCap),
        .core_out_bit_a(bitA), .core_out_bit_b(bitB), .core_oe_ctrl(oeCore),
        .strobe_read_shift_clk(1'b0), .strobe_write_shift_clk(strobeW),
        .capture_phase_select(capPol), .input_lag_setting(5'h00), .reg_addr(regAddr),
        .reg_wdata(regWdata), .reg_wr(regWr), .reg_rd(regRd), .reg_rdata(regRdata)
    );
    ioc_pad_model u_ioc_pad_model (.oe(padOe), .dOut(padOut), .extVal(padExt), .padIn(padIn));
    initial begin
        coreClk = 1'b0;
        forever #2.5 coreClk = ~coreClk;
    end
    // ======
    // shared tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        totalChecks++;
        if (s !== e) begin
            badCount++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge coreClk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge coreClk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge coreClk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge coreClk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge coreClk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", totalChecks, badCount);
        if (badCount == 0 && totalChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ======
    // scenarios
    task automatic tRegs();
        rd(`IOC_OFS_CFG, rv);
        chk("cfg reset", rv, 32'h80);
        rd(`IOC_OFS_STAT, rv);
        chk("stat edge", {29'h0, rv[9:7]}, 32'h4);
        wr(8'h08, 32'h3ff);
        rd(8'h08, rv);
        chk("unmapped", rv, 32'h0);
        rd(`IOC_OFS_CFG, rv);
        chk("cfg kept", rv, 32'h80);
    endtask
    task automatic tIn();
        padExt <= 1'b1;
        tick(2);
        chk("sdr fall", fallCap, 32'h1);
        chk("sdr rise", riseCap, 32'h0);
        wr(`IOC_OFS_CFG, 32'hc0);
        padExt <= 1'b0;
        tick(1);
        chk("lag early", fallCap, 32'h1);
        tick(1);
        chk("lag late", fallCap, 32'h0);
        wr(`IOC_OFS_CFG, 32'h81);
        padExt <= 1'b1;
        tick(1);
        padExt <= 1'b0;
        @(negedge coreClk);
        #1;
        chk("ddr rise", riseCap, 32'h1);
        chk("ddr fall", fallCap, 32'h0);
        // strobe side flips polarity; two sync edges pass inside the write
        capPol <= 1'b1;
        wr(`IOC_OFS_CFG, 32'h82);
        padExt <= 1'b1;
        tick(1);
        padExt <= 1'b0;
        @(negedge coreClk);
        #1;
        chk("mddr swap rise", riseCap, 32'h0);
        chk("mddr swap fall", fallCap, 32'h1);
        capPol <= 1'b0;
        tick(2);
        padExt <= 1'b1;
        tick(1);
        padExt <= 1'b0;
        @(negedge coreClk);
        #1;
        chk("mddr plain rise", riseCap, 32'h1);
        chk("mddr plain fall", fallCap, 32'h0);
    endtask
    task automatic tOut();
        wr(`IOC_OFS_CFG, 32'h80);
        bitA <= 1'b1;
        tick(1);
        chk("sdr flop", padOut, 32'h1);
        wr(`IOC_OFS_CFG, 32'h90);
        bitA <= 1'b0;
        #1;
        chk("latch open", padOut, 32'h0);
        wr(`IOC_OFS_CFG, 32'h84);
        for (int i = 0; i < 2; i++) begin
            bitA <= ~i[0];
            bitB <= i[0];
            tick(1);
            chk("ddr high", padOut, {31'h0, ~i[0]});
            @(negedge coreClk);
            #1;
            chk("ddr low", padOut, {31'h0, i[0]});
        end
        wr(`IOC_OFS_CFG, 32'h88);
        bitA <= 1'b1;
        bitB <= 1'b0;
        strobeW <= 1'b1;
        tick(1);
        @(negedge coreClk);
        #1;
        chk("strobe high", padOut, 32'h1);
        strobeW <= 1'b0;
        #1;
        chk("strobe low", padOut, 32'h0);
    endtask
    task automatic tOe();
        wr(`IOC_OFS_CFG, 32'h80);
        oeCore <= 1'b1;
        #1;
        chk("oe waits", padOe, 32'h0);
        tick(1);
        chk("oe reg", padOe, 32'h1);
        wr(`IOC_OFS_CFG, 32'h0);
        oeCore <= 1'b0;
        #1;
        chk("oe pass", padOe, 32'h0);
    endtask
    task automatic tBypass();
        wr(`IOC_OFS_CFG, 32'ha0);
        padExt <= 1'b1;
        #1;
        chk("bypass data", byComb, 32'h1);
        chk("bypass clock", byClk, 32'h1);
        wr(`IOC_OFS_CFG, 32'h80);
        #1;
        chk("bypass off", byComb, 32'h0);
    endtask
    task automatic tHold();
        wr(`IOC_OFS_CFG, 32'h380);
        bitA <= 1'b0;
        tick(1);
        ce <= 1'b0;
        bitA <= 1'b1;
        oeCore <= 1'b1;
        tick(2);
        chk("hold data", padOut, 32'h0);
        chk("hold oe", padOe, 32'h0);
        localSr <= 1'b1;
        tick(1);
        chk("init data", padOut, 32'h1);
        chk("init oe", padOe, 32'h1);
        localSr <= 1'b0;
        ce <= 1'b1;
    endtask
    initial begin
        {rstN, localSr, padExt, bitA, bitB, oeCore, strobeW, capPol, regWr, regRd} = 10'h0;
        ce = 1'b1;
        regAddr = 8'h0;
        regWdata = 32'h0;
        badCount = 0;
        totalChecks = 0;
        repeat (5) @(posedge coreClk);
        rstN <= 1'b1;
        repeat (3) @(posedge coreClk);
        tRegs();
        tIn();
        tOut();
        tOe();
        tBypass();
        tHold();
        finishTest();
    end
    initial begin
        #20000;
        badCount++;
        finishTest();
    end
endmodule // test_ioc_cell_logic
`default_nettype wire
